/* logic/wdt_sysreset.sv */
// Supervision timer with system-reset generator, AHB-Lite register slave.
// Assumes pins are asynchronous to clk_sys; one bus master, whole words only.
`include "wdt_sysreset_cfg.svh"

module supervision_reset
   import supervision_reset_pkg::*;
#(
   parameter int MS_CYCLES = `MS_TICK_NS / `CLK_PERIOD_NS
)(
   input  wire logic        clk_sys,         // System clock, 50 MHz
   input  wire logic        reset_n,         // Synchronous reset, active low
   input  wire logic        hsel,            // AHB slave select
   input  wire logic [31:0] haddr,           // AHB address
   input  wire logic [1:0]  htrans,          // AHB transfer type
   input  wire logic        hwrite,          // AHB write
   input  wire logic [2:0]  hsize,           // AHB size, word only
   input  wire logic [31:0] hwdata,          // AHB write data
   input  wire logic        hready,          // AHB bus ready
   output logic      [31:0] hrdata,          // AHB read data
   output logic             hreadyout,       // AHB slave ready
   output logic             hresp,           // AHB response, always OKAY
   input  wire logic        kick_input,      // Kick pin from processor
   input  wire logic [7:0]  rail_good_on,    // Rail above good-on threshold
   input  wire logic [7:0]  rail_good_off,   // Rail above good-off threshold
   input  wire logic [7:0]  general_input,   // General inputs, active high
   output logic             timeout_output,  // Timeout indication, active high
   output logic             sys_reset_n      // System reset, active low
);

   // ==============================================================
   // State registers
   state_type st;
   state_type next_st;

   logic        tick;
   logic        kick_pin;
   logic        wr_commit;
   logic        kick_bus;
   logic        sr_cfg_wr;
   logic        cond_on;
   logic        cond_lost;
   logic        wd_done;
   logic        sr_done;
   logic        to_fire;
   logic [20:0] wait_ms;
   logic [20:0] delay_ms;
   logic [20:0] period_ms;

   // Select to milliseconds: zero, then base doubling per step
   function automatic logic [20:0] sel_ms(input logic [4:0] sel, input logic [20:0] base, input logic [4:0] top);
      logic [4:0] s;
      s = (sel > top) ? top : sel;
      sel_ms = (s == 5'h00) ? 21'h000000 : 21'(base << (s - 5'h01));
   endfunction : sel_ms

   // Output is held low in these states
   function automatic logic sr_asserted(input sr_state_type s, input logic pulse_mode);
      case (s)
         SR_HOLD  : sr_asserted = 1'b1;
         SR_DELAY : sr_asserted = !pulse_mode;
         SR_PULSE : sr_asserted = 1'b1;
         SR_WDRST : sr_asserted = 1'b1;
         default  : sr_asserted = 1'b0;
      endcase
   endfunction : sr_asserted

   // ==============================================================
   // Derived terms
   assign tick      = (st.prescale == 16'(MS_CYCLES - 1));
   assign kick_pin  = st.kick_sync[1] ^ st.kick_sync[2];
   assign wr_commit = st.a_valid && st.a_write;
   assign kick_bus  = wr_commit && (st.a_addr == `ADDR_KICK);
   assign sr_cfg_wr = wr_commit && (st.a_addr == `ADDR_CTRL || st.a_addr == `ADDR_DELAY
                      || st.a_addr == `ADDR_PWIDTH || st.a_addr == `ADDR_SELECT);
   assign cond_on   = &(st.on_s2 | ~st.cfg.select[7:0]) && &(st.gi_s2 | ~st.cfg.select[15:8]);
   assign cond_lost = |(~st.off_s2 & st.cfg.select[7:0]) || |(~st.gi_s2 & st.cfg.select[15:8]);
   assign wait_ms   = sel_ms(st.cfg.wait_sel, `WAIT_STEP_MS, `WAIT_SEL_MAX);
   assign delay_ms  = sel_ms(st.cfg.delay_sel, 21'h000001, `SEL_MAX);
   assign period_ms = (st.cfg.period_ms == 18'h00000) ? 21'h000001 : 21'(st.cfg.period_ms);
   assign wd_done   = st.wd_cnt >= period_ms;
   assign to_fire   = (st.wd == WD_RUN) && wd_done && !(kick_pin || kick_bus);

   // Release timer target for the current phase
   always_comb
   begin
      case (st.sr)
         SR_PULSE : sr_done = st.sr_cnt >= 21'(st.cfg.pwidth_ms);
         default  : sr_done = st.sr_cnt >= delay_ms;
      endcase
   end

   // ==============================================================
   // Next state
   always_comb
   begin
      next_st = st;

      // Pin synchronisers, two flops before use
      next_st.kick_sync = {st.kick_sync[1:0], kick_input};
      next_st.on_s1     = rail_good_on;
      next_st.on_s2     = st.on_s1;
      next_st.off_s1    = rail_good_off;
      next_st.off_s2    = st.off_s1;
      next_st.gi_s1     = general_input;
      next_st.gi_s2     = st.gi_s1;

      // Millisecond prescaler
      next_st.prescale = tick ? 16'h0000 : st.prescale + 16'h0001;

      // Bus address phase capture, zero wait states
      next_st.a_valid = hsel && hready && (htrans == `HTRANS_NONSEQ);
      next_st.a_write = hwrite;
      next_st.a_addr  = haddr[7:0];
      if (hsel && hready && (htrans == `HTRANS_NONSEQ) && !hwrite)
      begin
         case (haddr[7:0])
            `ADDR_CTRL   : next_st.hrdata = 32'(st.cfg.ctrl);
            `ADDR_PERIOD : next_st.hrdata = 32'(st.cfg.period_ms);
            `ADDR_WAIT   : next_st.hrdata = 32'(st.cfg.wait_sel);
            `ADDR_DELAY  : next_st.hrdata = 32'(st.cfg.delay_sel);
            `ADDR_PWIDTH : next_st.hrdata = 32'(st.cfg.pwidth_ms);
            `ADDR_SELECT : next_st.hrdata = 32'(st.cfg.select);
            `ADDR_STATUS : next_st.hrdata = {25'h0000000, st.sr, st.wd, !st.sys_reset_n,
                                             st.wd == WD_EXPIRED};
            default      : next_st.hrdata = 32'h00000000;
         endcase
      end

      // Register writes in the data phase
      if (wr_commit)
      begin
         case (st.a_addr)
            `ADDR_CTRL   : next_st.cfg.ctrl      = hwdata[4:0];
            `ADDR_PERIOD : next_st.cfg.period_ms = hwdata[17:0];
            `ADDR_WAIT   : next_st.cfg.wait_sel  = hwdata[4:0];
            `ADDR_DELAY  : next_st.cfg.delay_sel = hwdata[4:0];
            `ADDR_PWIDTH : next_st.cfg.pwidth_ms = hwdata[14:0];
            `ADDR_SELECT : next_st.cfg.select    = hwdata[15:0];
            default      : ;
         endcase
      end

      // Supervision timer
      if (tick)
      begin
         next_st.wd_cnt = st.wd_cnt + 21'h000001;
      end
      case (st.wd)
         WD_OFF :
         begin
            next_st.wd_cnt = 21'h000000;
            if (st.cfg.ctrl[`CTRL_WD_EN])
            begin
               next_st.wd = WD_WAIT;
            end
         end
         WD_WAIT :
         begin
            if (st.wd_cnt >= wait_ms)
            begin
               next_st.wd     = WD_RUN;
               next_st.wd_cnt = 21'h000000;
            end
         end
         WD_RUN :
         begin
            if (kick_pin || kick_bus)
            begin
               next_st.wd_cnt = 21'h000000;
            end
            else if (wd_done)
            begin
               next_st.wd = st.cfg.ctrl[`CTRL_MERGE] ? WD_WAIT : WD_EXPIRED;
               next_st.wd_cnt = 21'h000000;
            end
         end
         WD_EXPIRED :
         begin
            if (kick_pin || kick_bus)
            begin
               next_st.wd     = WD_RUN;
               next_st.wd_cnt = 21'h000000;
            end
         end
         default : next_st.wd = WD_OFF;
      endcase
      if (!st.cfg.ctrl[`CTRL_WD_EN])
      begin
         next_st.wd = WD_OFF;
      end

      // Timeout output, level or timed pulse, unless merged
      if (tick && st.to_cnt != 21'h000000)
      begin
         next_st.to_cnt = st.to_cnt - 21'h000001;
      end
      if (to_fire && !st.cfg.ctrl[`CTRL_MERGE])
      begin
         next_st.to_cnt = `TO_PULSE_MS;
      end
      if (st.cfg.ctrl[`CTRL_TO_PULSE])
      begin
         next_st.timeout_output = next_st.to_cnt != 21'h000000;
      end
      else
      begin
         next_st.timeout_output = next_st.wd == WD_EXPIRED;
      end

      // System reset sequencer
      if (tick)
      begin
         next_st.sr_cnt = st.sr_cnt + 21'h000001;
      end
      case (st.sr)
         SR_HOLD :
         begin
            next_st.sr_cnt = 21'h000000;
            if (st.cfg.ctrl[`CTRL_SR_PULSE])
            begin
               next_st.sr = SR_ARM;
            end
            else if (cond_on)
            begin
               next_st.sr = SR_DELAY;
            end
         end
         SR_ARM :
         begin
            next_st.sr_cnt = 21'h000000;
            if (cond_on)
            begin
               next_st.sr = SR_DELAY;
            end
         end
         SR_DELAY :
         begin
            if (sr_done)
            begin
               next_st.sr     = st.cfg.ctrl[`CTRL_SR_PULSE] ? SR_PULSE : SR_RUN;
               next_st.sr_cnt = 21'h000000;
            end
         end
         SR_PULSE :
         begin
            if (sr_done)
            begin
               next_st.sr = SR_RUN;
            end
         end
         SR_WDRST :
         begin
            if (st.cfg.ctrl[`CTRL_TRACK])
            begin
               next_st.sr = SR_HOLD;
            end
            else if (sr_done)
            begin
               next_st.sr = SR_RUN;
            end
         end
         SR_RUN :
         begin
            next_st.sr_cnt = 21'h000000;
            if (cond_lost)
            begin
               next_st.sr = st.cfg.ctrl[`CTRL_SR_PULSE] ? SR_ARM : SR_HOLD;
            end
         end
         default : next_st.sr = SR_HOLD;
      endcase
      if (to_fire && st.cfg.ctrl[`CTRL_MERGE])
      begin
         next_st.sr     = SR_WDRST;
         next_st.sr_cnt = 21'h000000;
      end
      if (sr_cfg_wr)
      begin
         next_st.sr     = SR_HOLD;
         next_st.sr_cnt = 21'h000000;
      end
      next_st.sys_reset_n = !sr_asserted(next_st.sr, next_st.cfg.ctrl[`CTRL_SR_PULSE]);
   end

   // ==============================================================
   // State register
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         st                <= '0;
         st.cfg.ctrl       <= `RST_CTRL;
         st.cfg.period_ms  <= `RST_PERIOD;
         st.cfg.wait_sel   <= `RST_WAIT;
         st.cfg.delay_sel  <= `RST_DELAY;
         st.cfg.pwidth_ms  <= `RST_PWIDTH;
         st.cfg.select     <= `RST_SELECT;
         st.wd             <= WD_OFF;
         st.sr             <= SR_HOLD;
         st.sys_reset_n    <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flops, bus ready and response tied off
   assign hrdata         = st.hrdata;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign timeout_output = st.timeout_output;
   assign sys_reset_n    = st.sys_reset_n;

   // ==============================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_kick_pin_restart: assert property ((st.wd == WD_RUN) && kick_pin |=> st.wd_cnt == 21'h000000)
      else $error("pin kick did not restart timer");
   a_timeout_declared: assert property (to_fire && !st.cfg.ctrl[`CTRL_MERGE] |=> st.wd == WD_EXPIRED)
      else $error("missed timeout");
   a_bus_kick_restart: assert property ((st.wd == WD_RUN) && kick_bus |=> st.wd_cnt == 21'h000000)
      else $error("bus kick did not restart timer");
   a_resume_kick: assert property ((st.wd == WD_EXPIRED) && (kick_pin || kick_bus)
                                   && st.cfg.ctrl[`CTRL_WD_EN] |=> st.wd == WD_RUN)
      else $error("no resume after kick");
   a_release_delayed: assert property ($rose(sys_reset_n) && !st.cfg.ctrl[`CTRL_SR_PULSE]
                                       |-> $past(st.sr) == SR_DELAY || $past(st.sr) == SR_WDRST)
      else $error("reset released without delay");
   a_level_drop: assert property ((st.sr == SR_RUN) && cond_lost && !st.cfg.ctrl[`CTRL_SR_PULSE]
                                  |=> !sys_reset_n)
      else $error("reset not asserted on drop");
   a_pulse_width: assert property ($rose(st.sr == SR_PULSE) |-> !sys_reset_n [*2])
      else $error("reset pulse too short");
   a_merge_toggle: assert property (to_fire && st.cfg.ctrl[`CTRL_MERGE] && !sr_cfg_wr
                                    |=> !sys_reset_n && st.sr == SR_WDRST)
      else $error("merged timeout did not assert reset");
   a_cfg_reassert: assert property (sr_cfg_wr |=> !sys_reset_n)
      else $error("reset not asserted on reconfig");
   a_reset_asserted: assert property (@(posedge clk_sys) disable iff (1'b0) !reset_n |=> !sys_reset_n)
      else $error("reset output not asserted after reset");

   c_timeout: cover property (to_fire && !st.cfg.ctrl[`CTRL_MERGE]);
   c_merge: cover property (st.sr == SR_WDRST ##1 st.sr == SR_RUN);
   c_pulse: cover property (st.sr == SR_PULSE ##1 st.sr == SR_RUN);
   c_release: cover property ($rose(sys_reset_n));

endmodule : supervision_reset

/* include/wdt_sysreset_cfg.svh */
// Constants for the supervision timer and system-reset block.
// Assumes a 50 MHz clk_sys and a 32-bit AHB-Lite register port.
`ifndef SUPERVISION_RESET_CFG_SVH
`define SUPERVISION_RESET_CFG_SVH

// ==============================================================
// Timing
`define CLK_PERIOD_NS   20
`define MS_TICK_NS      1000000
`define WAIT_STEP_MS    21'h000064
`define TO_PULSE_MS     21'h000001
`define SEL_MAX         5'h10
`define WAIT_SEL_MAX    5'h0f

// ==============================================================
// Register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_KICK       8'h04
`define ADDR_PERIOD     8'h08
`define ADDR_WAIT       8'h0c
`define ADDR_DELAY      8'h10
`define ADDR_PWIDTH     8'h14
`define ADDR_SELECT     8'h18
`define ADDR_STATUS     8'h1c

// ==============================================================
// Control bit positions
`define CTRL_WD_EN      0
`define CTRL_MERGE      1
`define CTRL_TO_PULSE   2
`define CTRL_SR_PULSE   3
`define CTRL_TRACK      4

// ==============================================================
// Reset values and the NONSEQ transfer code
`define RST_CTRL        5'h00
`define RST_PERIOD      18'h003e8
`define RST_WAIT        5'h00
`define RST_DELAY       5'h01
`define RST_PWIDTH      15'h0001
`define RST_SELECT      16'h0000
`define HTRANS_NONSEQ   2'h2

`endif

/* include/wdt_sysreset_pkg.sv */
// Types for the supervision timer and system-reset block.
// Assumes wdt_sysreset_cfg.svh supplies the widths' reset values.
package supervision_reset_pkg;

   // ==============================================================
   // State machines
   typedef enum logic [1:0] {WD_OFF, WD_WAIT, WD_RUN, WD_EXPIRED} wd_state_type;
   typedef enum logic [2:0] {SR_HOLD, SR_ARM, SR_DELAY, SR_PULSE, SR_RUN, SR_WDRST} sr_state_type;

   // ==============================================================
   // Software configuration
   typedef struct packed {
      logic [4:0]  ctrl;
      logic [17:0] period_ms;
      logic [4:0]  wait_sel;
      logic [4:0]  delay_sel;
      logic [14:0] pwidth_ms;
      logic [15:0] select;
   } cfg_type;

   // ==============================================================
   // Whole module state
   typedef struct packed {
      cfg_type      cfg;
      logic [2:0]   kick_sync;
      logic [7:0]   on_s1, on_s2, off_s1, off_s2, gi_s1, gi_s2;
      logic [15:0]  prescale;
      wd_state_type wd;
      logic [20:0]  wd_cnt;
      logic [20:0]  to_cnt;
      sr_state_type sr;
      logic [20:0]  sr_cnt;
      logic         a_valid;
      logic         a_write;
      logic [7:0]   a_addr;
      logic [31:0]  hrdata;
      logic         timeout_output;
      logic         sys_reset_n;
   } state_type;

endpackage : supervision_reset_pkg

/* tb/kick_host.sv */
// Host processor model that keeps the supervision timer alive via the kick pin.
// Assumes run and gap are driven by the bench; toggles change right after clk_sys edges.
module kick_host (
   input  wire logic       clk_sys,     // System clock
   input  wire logic       run,         // Keep toggling while high
   input  wire logic [7:0] gap,         // Cycles between toggles, minus one
   output logic            kick_input   // Kick pin to the device
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] count;

   // ==============================================================
   // Toggle generator
   initial kick_input = 1'b0;
   initial count = 8'h00;

   // Toggle the pin once every gap+1 cycles; stop toggling to force a timeout
   always @(posedge clk_sys)
   begin
      if (!run)
      begin
         count <= 8'h00;
      end
      else if (count >= gap)
      begin
         count      <= 8'h00;
         kick_input <= ~kick_input;
      end
      else
      begin
         count <= count + 8'h01;
      end
   end
endmodule : kick_host

/* tb/watchdog_and_system_reset_tb.sv */
// Self-checking bench for the supervision timer and system-reset block.
// Assumes MS_CYCLES of 10, so one millisecond is ten clk_sys cycles.
`include "wdt_sysreset_cfg.svh"
`define CHECK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module watchdog_and_system_reset_tb;
   import supervision_reset_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   wire         hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   wire         kick_input;
   logic        kick_run = 1'b0;
   logic [7:0]  rail_good_on = 8'h00;
   logic [7:0]  rail_good_off = 8'h00;
   logic [7:0]  general_input = 8'h00;
   logic        timeout_output;
   logic        sys_reset_n;
   int          fail_count = 0;
   int          checks = 0;
   logic [31:0] rd;

   // ==============================================================
   // Clock, bus ready loop and instances
   always #10 clk_sys = ~clk_sys;
   assign hready = hreadyout;

   supervision_reset #(.MS_CYCLES(10)) dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .kick_input(kick_input), .rail_good_on(rail_good_on),
      .rail_good_off(rail_good_off), .general_input(general_input), .timeout_output(timeout_output),
      .sys_reset_n(sys_reset_n));

   kick_host host (.clk_sys(clk_sys), .run(kick_run), .gap(8'd14), .kick_input(kick_input));

   // ==============================================================
   // Bus tasks: address phase held until ready, then data phase
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= `HTRANS_NONSEQ;
      hwrite <= 1'b1;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
   endtask : bus_write

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= `HTRANS_NONSEQ;
      hwrite <= 1'b0;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      do @(posedge clk_sys); while (hready !== 1'b1);
      d = hrdata;
   endtask : bus_read

   // Read one register and compare with the expected word
   task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      bus_read(a, d);
      `CHECK(nm, exp, d)
      `CHECK("hresp", 1'b0, hresp)
      `CHECK("hreadyout", 1'b1, hreadyout)
   endtask : read_check

   // Wait for an output (0 reset line, 1 timeout) to reach val; the wait must fall in lo..hi cycles
   task automatic await(input bit sel, input logic val, input int lo, input int hi, input string nm);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (((sel ? timeout_output : sys_reset_n) !== val) && n <= hi);
      `CHECK(nm, 1'b1, (n >= lo && n <= hi))
   endtask : await

   // The output must keep val for c cycles
   task automatic hold(input bit sel, input logic val, input int c, input string nm);
      int bad;
      bad = 0;
      repeat (c)
      begin
         @(posedge clk_sys);
         if ((sel ? timeout_output : sys_reset_n) !== val) bad++;
      end
      `CHECK(nm, 0, bad)
   endtask : hold

   // Print the verdict and end the run
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // ==============================================================
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      wrap_up();
   end

   // ==============================================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      `CHECK("reset_during_init", 1'b0, sys_reset_n)
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      `CHECK("reset_at_release", 1'b0, sys_reset_n)
      // Reset values and an unmapped place
      read_check(`ADDR_PERIOD, 32'h3e8, "period_reset");
      read_check(`ADDR_DELAY, 32'h1, "delay_reset");
      read_check(`ADDR_PWIDTH, 32'h1, "pwidth_reset");
      read_check(`ADDR_CTRL, 32'h0, "ctrl_reset");
      bus_write(8'h20, 32'hffff_ffff);
      read_check(8'h20, 32'h0, "unmapped_read");
      // Level mode with nothing selected: released after the 1 ms delay
      await(0, 1'b1, 1, 60, "release_default");
      // Select rail 0 and input 0: reconfig asserts, conditions hold it
      bus_write(`ADDR_SELECT, 32'h0101);
      await(0, 1'b0, 1, 3, "reconfig_assert");
      hold(0, 1'b0, 80, "hold_without_good");
      rail_good_on  <= 8'h01;
      rail_good_off <= 8'h01;
      hold(0, 1'b0, 20, "hold_without_input");
      general_input <= 8'h01;
      await(0, 1'b1, 5, 30, "release_all_good");
      general_input <= 8'h00;
      await(0, 1'b0, 1, 6, "drop_input");
      general_input <= 8'h01;
      await(0, 1'b1, 5, 30, "rerelease");
      rail_good_off <= 8'h00;
      await(0, 1'b0, 1, 6, "drop_rail");
      rail_good_off <= 8'h01;
      // Longer delay: 4 ms
      bus_write(`ADDR_DELAY, 32'h3);
      await(0, 1'b1, 25, 60, "delay_4ms");
      bus_write(`ADDR_DELAY, 32'h1);
      // Watchdog, 3 ms period, kicks by pin
      bus_write(`ADDR_PERIOD, 32'h3);
      read_check(`ADDR_PERIOD, 32'h3, "period_rw");
      kick_run <= 1'b1;
      bus_write(`ADDR_CTRL, 32'h1);
      hold(1, 1'b0, 200, "pin_kicks_keep_alive");
      kick_run <= 1'b0;
      await(1, 1'b1, 1, 60, "timeout_level");
      hold(1, 1'b1, 50, "timeout_stays");
      read_check(`ADDR_STATUS, 32'h4d, "status_expired");
      bus_write(`ADDR_KICK, 32'h1);
      await(1, 1'b0, 1, 5, "bus_kick_resumes");
      repeat (8)
      begin
         repeat (15) @(posedge clk_sys);
         bus_write(`ADDR_KICK, 32'h0);
         `CHECK("bus_kick_keep_alive", 1'b0, timeout_output)
      end
      // Pulsed timeout, then pin kick out of expiry
      bus_write(`ADDR_CTRL, 32'h5);
      await(1, 1'b1, 1, 60, "pulse_start");
      await(1, 1'b0, 5, 15, "pulse_width");
      hold(1, 1'b0, 30, "single_pulse");
      kick_run <= 1'b1;
      hold(1, 1'b0, 150, "pin_resumes");
      kick_run <= 1'b0;
      // Initial wait of 100 ms before supervision begins
      bus_write(`ADDR_CTRL, 32'h0);
      bus_write(`ADDR_WAIT, 32'h1);
      bus_write(`ADDR_CTRL, 32'h1);
      hold(1, 1'b0, 900, "initial_wait");
      await(1, 1'b1, 1, 250, "after_wait");
      // Merged into system reset
      bus_write(`ADDR_CTRL, 32'h0);
      bus_write(`ADDR_WAIT, 32'h0);
      bus_write(`ADDR_CTRL, 32'h3);
      await(0, 1'b1, 1, 60, "merged_release");
      `CHECK("merged_no_timeout_pin", 1'b0, timeout_output)
      await(0, 1'b0, 15, 60, "merged_expiry");
      await(0, 1'b1, 1, 60, "merged_rerelease");
      // Merged with input-tracking release
      bus_write(`ADDR_CTRL, 32'h0);
      bus_write(`ADDR_CTRL, 32'h13);
      await(0, 1'b1, 1, 60, "track_release");
      await(0, 1'b0, 15, 60, "track_expiry");
      await(0, 1'b1, 1, 60, "track_rerelease");
      // Pulse mode: released, then one pulse of 2 ms once good
      bus_write(`ADDR_CTRL, 32'h0);
      bus_write(`ADDR_PWIDTH, 32'h2);
      rail_good_on  <= 8'h00;
      rail_good_off <= 8'h00;
      bus_write(`ADDR_CTRL, 32'h8);
      await(0, 1'b1, 1, 10, "pulse_arm");
      hold(0, 1'b1, 40, "pulse_wait_good");
      rail_good_on  <= 8'h01;
      rail_good_off <= 8'h01;
      await(0, 1'b0, 3, 40, "pulse_low");
      await(0, 1'b1, 8, 35, "pulse_width_sr");
      hold(0, 1'b1, 60, "pulse_once");
      wrap_up();
   end
endmodule : watchdog_and_system_reset_tb
